// [logic/ffod_pkg.sv]
// constants for the free-fall and orientation event block
// assumes an 8-bit register port and samples scaled to milli-g
package ffod_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] FFOD_ADDR_FF_CFG   = 8'h10;
  localparam logic [7:0] FFOD_ADDR_WU_DUR   = 8'h11;
  localparam logic [7:0] FFOD_ADDR_ROUTE    = 8'h12;
  localparam logic [7:0] FFOD_ADDR_INT_CFG  = 8'h13;
  localparam logic [7:0] FFOD_ADDR_OR_CFG   = 8'h14;
  localparam logic [7:0] FFOD_ADDR_WU_SRC   = 8'h15;
  localparam logic [7:0] FFOD_ADDR_OR_SRC   = 8'h16;
  localparam logic [7:0] FFOD_ADDR_ALL_SRC  = 8'h17;

  // values after reset
  localparam logic [7:0] FFOD_RST_REG       = 8'h00;
  localparam logic [5:0] FFOD_RST_CNT       = 6'h00;

  // field positions
  localparam int FFOD_FF_THR_LSB   = 5;   // freefall_threshold [7:5]
  localparam int FFOD_FREEFALL_DURATION_LSB   = 0;   // freefall_duration [4:0]
  localparam int FFOD_FREEFALL_DURATION_MSB_B = 7;   // freefall_duration_msb
  localparam int FFOD_RT_FF_BIT    = 4;   // route_freefall_to_pin
  localparam int FFOD_RT_OR_BIT    = 2;   // route_orientation_to_pin
  localparam int FFOD_IC_EN_BIT    = 0;   // basic interrupts enable
  localparam int FFOD_IC_LATCH_BIT = 1;   // latch_enable
  localparam int FFOD_OR_THR_LSB   = 5;   // orientation_threshold [6:5]
  localparam int FFOD_OR_4D_BIT    = 7;   // four_direction_enable
  localparam int FFOD_WS_FF_BIT    = 5;   // freefall_flag
  localparam int FFOD_OS_CHG_BIT   = 6;   // orientation_change_flag
  localparam int FFOD_AS_FF_BIT    = 0;   // freefall_flag_combined
  localparam int FFOD_AS_OR_BIT    = 2;   // orientation_flag_combined

  localparam logic [5:0] FFOD_CNT_MAX = 6'h3F;

  // free-fall zone half width in milli-g per threshold code
  localparam logic [15:0] FFOD_FF_THR_TBL [0:7] = '{
    16'h009C, 16'h00DB, 16'h00FA, 16'h0138,
    16'h0158, 16'h0196, 16'h01D5, 16'h01F4
  };

  // 1 g times sine of 80/70/60/50 degrees, in milli-g
  localparam logic [15:0] FFOD_OR_THR_TBL [0:3] = '{
    16'h03D9, 16'h03AC, 16'h0362, 16'h02FE
  };

endpackage

// [logic/ffod_core.sv]
// free-fall and 6D/4D orientation event logic with its registers
// assumes one sample strobe per output data period, same clock,
// and a simple synchronous register port driven by the serial front end
//
// Operation
// - freefall routing bit drives pin
// - freefall flag in two source registers
// - level mode drops when condition ends
// - latched freefall held until flag read
// - six-bit duration split across two registers
// - ignore freefall shorter than duration
// - three-bit freefall threshold, 156 to 500
// - orientation event only on position change
// - exactly one axis above, others below
// - change flag bit6, positions bits5..0
// - up flag positive, down flag negative
// - two-bit angle threshold 80 to 50
// - orientation routed and mirrored in sources
// - level orientation pulse one ODR period
// - latched orientation held until flag read
// - position bits always live
// - four-direction mode skips Z axis
// - freefall means all axes near zero
// - latch enable selects latched mode
`timescale 1ns/1ps

module ffod_core (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  output logic      [7:0]         reg_rdata_o,
  output logic                    reg_rvalid_o,
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] accel_x_i,
  input  wire logic signed [15:0] accel_y_i,
  input  wire logic signed [15:0] accel_z_i,
  output logic                    int_o
);
  import ffod_pkg::*;

  logic [7:0] ff_cfg_r;
  logic [7:0] wu_dur_r;
  logic [7:0] route_r;
  logic [7:0] int_cfg_r;
  logic [7:0] or_cfg_r;
  logic [5:0] ff_cnt_r;
  logic       ff_flag_r;
  logic       or_flag_r;
  logic [5:0] pos_r;
  logic [5:0] last_pos_r;
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic       int_r;

  // register decode
  wire wr_ff_cfg  = reg_wr_i && (reg_addr_i == FFOD_ADDR_FF_CFG);
  wire wr_wu_dur  = reg_wr_i && (reg_addr_i == FFOD_ADDR_WU_DUR);
  wire wr_route   = reg_wr_i && (reg_addr_i == FFOD_ADDR_ROUTE);
  wire wr_int_cfg = reg_wr_i && (reg_addr_i == FFOD_ADDR_INT_CFG);
  wire wr_or_cfg  = reg_wr_i && (reg_addr_i == FFOD_ADDR_OR_CFG);
  wire rd_wu_src  = reg_rd_i && (reg_addr_i == FFOD_ADDR_WU_SRC);
  wire rd_or_src  = reg_rd_i && (reg_addr_i == FFOD_ADDR_OR_SRC);
  wire rd_all_src = reg_rd_i && (reg_addr_i == FFOD_ADDR_ALL_SRC);

  // configuration fields
  wire       latch_enable = int_cfg_r[FFOD_IC_LATCH_BIT];
  wire       int_enable   = int_cfg_r[FFOD_IC_EN_BIT];
  wire       route_ff     = route_r[FFOD_RT_FF_BIT];
  wire       route_or     = route_r[FFOD_RT_OR_BIT];
  wire       four_dir     = or_cfg_r[FFOD_OR_4D_BIT];
  wire [2:0] ff_thr_code  = ff_cfg_r[FFOD_FF_THR_LSB +: 3];
  wire [1:0] or_thr_code  = or_cfg_r[FFOD_OR_THR_LSB +: 2];
  wire [5:0] ff_duration  = {wu_dur_r[FFOD_FREEFALL_DURATION_MSB_B],
                             ff_cfg_r[FFOD_FREEFALL_DURATION_LSB +: 5]};

  wire [15:0] ff_thr = FFOD_FF_THR_TBL[ff_thr_code];
  wire [15:0] or_thr = FFOD_OR_THR_TBL[or_thr_code];

  // per-axis magnitude compares; samples arrive already in milli-g,
  // which keeps both thresholds independent of full scale
  logic signed [15:0] accel [0:2];
  logic [2:0] axis_small;
  logic [2:0] axis_big;
  logic [2:0] axis_neg;
  assign accel[0] = accel_x_i;
  assign accel[1] = accel_y_i;
  assign accel[2] = accel_z_i;

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis
      wire [15:0] mag = accel[ax][15] ? 16'(-accel[ax]) : accel[ax];
      assign axis_neg[ax]   = accel[ax][15];
      assign axis_small[ax] = mag < ff_thr;
      assign axis_big[ax]   = mag > or_thr;
    end
  endgenerate

  wire [2:0] big_masked = axis_big & (four_dir ? 3'h3 : 3'h7);
  wire       one_big    = (big_masked != 3'h0) &&
                          ((big_masked & (big_masked - 3'h1)) == 3'h0);
  wire [2:0] axis_sel   = one_big ? big_masked : 3'h0;

  logic [5:0] pos_w;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_pos
      // up on positive, down on negative
      assign pos_w[2*ax+1] = axis_sel[ax] & ~axis_neg[ax];
      assign pos_w[2*ax]   = axis_sel[ax] &  axis_neg[ax];
    end
  endgenerate

  // free-fall duration tracking
  wire       all_small  = &axis_small;
  wire [5:0] cnt_inc    = (ff_cnt_r == FFOD_CNT_MAX) ? ff_cnt_r
                                                     : ff_cnt_r + 6'h1;
  wire [5:0] cnt_new    = all_small ? cnt_inc : FFOD_RST_CNT;
  wire       ff_met     = all_small && (cnt_new >= ff_duration);
  wire       ff_set     = sample_valid_i && ff_met;

  wire ff_clr = rd_wu_src || rd_all_src;
  wire or_clr = rd_or_src || rd_all_src;

  // a pending latched change blocks new ones until it is read
  wire or_block  = latch_enable && or_flag_r && !or_clr;
  wire or_chg    = sample_valid_i && (pos_w != 6'h00) &&
                   (pos_w != last_pos_r) && !or_block;

  // latched against level; set wins over a same-cycle clear
  wire ff_flag_nxt = latch_enable ? (ff_set || (ff_flag_r && !ff_clr))
                                  : (sample_valid_i ? ff_met : ff_flag_r);
  // level lasts until the next sample
  wire or_flag_nxt = latch_enable ? (or_chg || (or_flag_r && !or_clr))
                                  : (sample_valid_i ? or_chg : or_flag_r);

  wire int_nxt = int_enable && ((route_ff && ff_flag_nxt) ||
                                (route_or && or_flag_nxt));

  wire [7:0] wu_src_w  = 8'(ff_flag_r) << FFOD_WS_FF_BIT;
  wire [7:0] or_src_w  = (8'(or_flag_r) << FFOD_OS_CHG_BIT) | {2'b00, pos_r};
  wire [7:0] all_src_w = (8'(ff_flag_r) << FFOD_AS_FF_BIT) |
                         (8'(or_flag_r) << FFOD_AS_OR_BIT);
  wire [7:0] rd_mux_w  =
    (reg_addr_i == FFOD_ADDR_FF_CFG)  ? ff_cfg_r  :
    (reg_addr_i == FFOD_ADDR_WU_DUR)  ? wu_dur_r  :
    (reg_addr_i == FFOD_ADDR_ROUTE)   ? route_r   :
    (reg_addr_i == FFOD_ADDR_INT_CFG) ? int_cfg_r :
    (reg_addr_i == FFOD_ADDR_OR_CFG)  ? or_cfg_r  :
    (reg_addr_i == FFOD_ADDR_WU_SRC)  ? wu_src_w  :
    (reg_addr_i == FFOD_ADDR_OR_SRC)  ? or_src_w  :
    (reg_addr_i == FFOD_ADDR_ALL_SRC) ? all_src_w : 8'h00;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff_cfg_r  <= FFOD_RST_REG;
      wu_dur_r  <= FFOD_RST_REG;
      route_r   <= FFOD_RST_REG;
      int_cfg_r <= FFOD_RST_REG;
      or_cfg_r  <= FFOD_RST_REG;
    end else begin
      if (wr_ff_cfg)  ff_cfg_r  <= reg_wdata_i;
      if (wr_wu_dur)  wu_dur_r  <= reg_wdata_i;
      if (wr_route)   route_r   <= reg_wdata_i;
      if (wr_int_cfg) int_cfg_r <= reg_wdata_i;
      if (wr_or_cfg)  or_cfg_r  <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff_cnt_r   <= FFOD_RST_CNT;
      pos_r      <= 6'h00;
      last_pos_r <= 6'h00;
    end else if (sample_valid_i) begin
      ff_cnt_r <= cnt_new;
      pos_r    <= pos_w;
      if (or_chg) last_pos_r <= pos_w;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff_flag_r <= 1'b0;
      or_flag_r <= 1'b0;
      int_r     <= 1'b0;
      rdata_r   <= 8'h00;
      rvalid_r  <= 1'b0;
    end else begin
      ff_flag_r <= ff_flag_nxt;
      or_flag_r <= or_flag_nxt;
      int_r     <= int_nxt;
      rvalid_r  <= reg_rd_i;
      if (reg_rd_i) rdata_r <= rd_mux_w;
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign int_o        = int_r;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence or_level_set_s;
    !latch_enable && or_chg;
  endsequence

  sequence no_sample_s;
    !sample_valid_i && !$changed(latch_enable);
  endsequence

  ff_route_pin_a: assert property (
    (int_enable && route_ff && ff_flag_nxt) |=> int_o)
    else $error("free-fall flag not on pin");

  ff_level_drop_a: assert property (
    (!latch_enable && sample_valid_i && !ff_met) |=> !ff_flag_r)
    else $error("level free-fall not dropped");

  ff_latch_hold_a: assert property (
    (latch_enable && ff_flag_r && !ff_clr) |=> ff_flag_r)
    else $error("latched free-fall lost without read");

  ff_short_ign_a: assert property (
    (!latch_enable && sample_valid_i && cnt_new < ff_duration)
      |=> !ff_flag_r)
    else $error("short free-fall detected");

  or_no_repeat_a: assert property (
    (sample_valid_i && pos_w == last_pos_r && !or_flag_r)
      |=> !or_flag_r)
    else $error("orientation reasserted on same position");

  or_one_axis_a: assert property (
    (pos_r != 6'h00) |-> $onehot(pos_r))
    else $error("more than one position flag");

  or_level_pulse_a: assert property (
    or_level_set_s ##1 no_sample_s |=> or_flag_r)
    else $error("level orientation pulse too short");

  or_level_end_a: assert property (
    (!latch_enable && or_flag_r && sample_valid_i && !or_chg)
      |=> !or_flag_r)
    else $error("level orientation pulse too long");

  or_latch_clr_a: assert property (
    (latch_enable && or_flag_r && or_clr && !or_chg) |=> !or_flag_r)
    else $error("latched orientation not cleared by read");

  or_four_dir_a: assert property (
    (sample_valid_i && four_dir) |=> (pos_r[5:4] == 2'b00))
    else $error("z position reported in four-direction mode");

  pin_gated_a: assert property (
    (!route_ff && !route_or) |=> !int_o)
    else $error("pin raised with routing off");

  ff_latch_clr_a: assert property (
    (latch_enable && ff_flag_r && ff_clr && !ff_set) |=> !ff_flag_r)
    else $error("latched free-fall not cleared by read");

  ff_detect_a: assert property (
    (sample_valid_i && ff_met) |=> ff_flag_r)
    else $error("free-fall zone not detected");

  ff_no_sample_a: assert property (
    (!sample_valid_i && !latch_enable) |=> $stable(ff_flag_r))
    else $error("free-fall flag moved between samples");

  or_change_set_a: assert property (
    or_chg |=> or_flag_r)
    else $error("orientation change not flagged");

  pos_live_a: assert property (
    sample_valid_i |=> (pos_r == $past(pos_w)))
    else $error("position bits not live");

  pin_enable_off_a: assert property (
    !int_enable |=> !int_o)
    else $error("pin raised with interrupts disabled");

endmodule

// [tb/ffod_host.sv]
// host model: master of the event block's register port
// assumes strobes are taken on the rising edge of the shared clock
`timescale 1ns/1ps

module ffod_host (
  input  wire logic       clk_sys_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'hFF;
    reg_wdata_o = 8'hFF;
  end

  // idle lines show the inverse so stale values never read as valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    // data is taken at the edge where the answer strobe is seen
    @(posedge clk_sys_i iff reg_rvalid_i);
    d = reg_rdata_i;
  endtask
endmodule

// [tb/tb_ffod_core.sv]
// self-checking bench for the free-fall and orientation event block
// assumes the host model owns the register port
`timescale 1ns/1ps

module tb_ffod_core;
  import ffod_pkg::*;
  logic               clk_sys_i;
  logic               rst_n_i;
  logic               sample_valid_i;
  logic signed [15:0] accel_x_i;
  logic signed [15:0] accel_y_i;
  logic signed [15:0] accel_z_i;
  logic               reg_wr_i;
  logic               reg_rd_i;
  logic [7:0]         reg_addr_i;
  logic [7:0]         reg_wdata_i;
  logic [7:0]         reg_rdata_o;
  logic               reg_rvalid_o;
  logic               int_o;
  logic [7:0]         rv;
  int                 n_mismatch;
  int                 checks;
  int                 cyc;
  int                 ffthr [8] = '{156, 219, 250, 312, 344, 406, 469, 500};
  int                 orthr [4] = '{985, 940, 866, 766};

  ffod_core u_ffod_core (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .sample_valid_i, .accel_x_i, .accel_y_i, .accel_z_i, .int_o);
  ffod_host u_ffod_host (.clk_sys_i, .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));

  initial clk_sys_i = 1'b0;
  always #25 clk_sys_i = ~clk_sys_i;

  task automatic end_of_test();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs about 400 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_ffod_host.rd(a, rv);
    chk8(rv, e);
    // step off the edge so later pin checks see settled outputs
    #1;
  endtask

  task automatic smp(input int x, input int y, input int z);
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b1;
    accel_x_i <= 16'(x);
    accel_y_i <= 16'(y);
    accel_z_i <= 16'(z);
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b0;
    #1;
  endtask

  task automatic gap2();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  function automatic logic [7:0] pbit(input int p);
    return 8'(1 << p);
  endfunction

  initial begin
    int t, ry, m, k;
    rst_n_i = 1'b0;
    sample_valid_i = 1'b0;
    accel_x_i = '0;
    accel_y_i = '0;
    accel_z_i = '0;
    cyc = 0;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(32'h0113));
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 16; a <= 24; a++) rdc(8'(a), 8'h00);
    $display("reset values done");
    u_ffod_host.wr(FFOD_ADDR_ROUTE, 8'h10);
    u_ffod_host.wr(FFOD_ADDR_INT_CFG, 8'h01);
    for (int c = 0; c < 8; c++) begin
      t = ffthr[c] - 1;
      ry = $urandom_range(2 * t, 0) - t;
      u_ffod_host.wr(FFOD_ADDR_FF_CFG, 8'(c << 5));
      smp(t, ry, -t);
      chk1(int_o, 1'b1);
      rdc(FFOD_ADDR_WU_SRC, 8'h20);
      rdc(FFOD_ADDR_ALL_SRC, 8'h01);
      smp(-t - 1, ry, 0);
      chk1(int_o, 1'b0);
    end
    $display("free-fall level done");
    u_ffod_host.wr(FFOD_ADDR_FF_CFG, 8'h01);
    u_ffod_host.wr(FFOD_ADDR_WU_DUR, 8'h80);
    repeat (32) smp(0, 0, 0);
    chk1(int_o, 1'b0);
    smp(0, 0, 0);
    chk1(int_o, 1'b1);
    u_ffod_host.wr(FFOD_ADDR_WU_DUR, 8'h00);
    u_ffod_host.wr(FFOD_ADDR_ROUTE, 8'h00);
    smp(0, 0, 0);
    chk1(int_o, 1'b0);
    rdc(FFOD_ADDR_WU_SRC, 8'h20);
    u_ffod_host.wr(FFOD_ADDR_ROUTE, 8'h10);
    u_ffod_host.wr(FFOD_ADDR_INT_CFG, 8'h00);
    smp(0, 0, 0);
    chk1(int_o, 1'b0);
    $display("duration and routing done");
    u_ffod_host.wr(FFOD_ADDR_ROUTE, 8'h10);
    u_ffod_host.wr(FFOD_ADDR_INT_CFG, 8'h03);
    for (int i = 0; i < 2; i++) begin
      smp(0, 0, 0);
      smp(300, 0, 0);
      chk1(int_o, 1'b1);
      if (i == 0) rdc(FFOD_ADDR_WU_SRC, 8'h20);
      else rdc(FFOD_ADDR_ALL_SRC, 8'h01);
      gap2();
      chk1(int_o, 1'b0);
    end
    $display("free-fall latched done");
    u_ffod_host.wr(FFOD_ADDR_INT_CFG, 8'h01);
    u_ffod_host.wr(FFOD_ADDR_ROUTE, 8'h04);
    for (int p = 0; p < 6; p++) begin
      k = $urandom_range(3, 0);
      m = orthr[k] + 1 + $urandom_range(100, 0);
      if (p % 2 == 0) m = -m;
      u_ffod_host.wr(FFOD_ADDR_OR_CFG, 8'(k << 5));
      // exactly on the angle threshold must not count as a position
      t = (p % 2 == 0) ? -orthr[k] : orthr[k];
      smp(p / 2 == 0 ? t : 0, p / 2 == 1 ? t : 0, p / 2 == 2 ? t : 0);
      rdc(FFOD_ADDR_OR_SRC, 8'h00);
      smp(p / 2 == 0 ? m : 0, p / 2 == 1 ? m : 0, p / 2 == 2 ? m : 0);
      chk1(int_o, 1'b1);
      rdc(FFOD_ADDR_OR_SRC, 8'h40 | pbit(p));
      rdc(FFOD_ADDR_ALL_SRC, 8'h04);
      chk1(int_o, 1'b1);
      smp(p / 2 == 0 ? m : 0, p / 2 == 1 ? m : 0, p / 2 == 2 ? m : 0);
      chk1(int_o, 1'b0);
      rdc(FFOD_ADDR_OR_SRC, pbit(p));
    end
    smp(1000, 1000, 0);
    u_ffod_host.rd(FFOD_ADDR_OR_SRC, rv);
    chk8(rv & 8'h3F, 8'h00);
    u_ffod_host.wr(FFOD_ADDR_OR_CFG, 8'h80);
    smp(0, 0, 1000);
    u_ffod_host.rd(FFOD_ADDR_OR_SRC, rv);
    chk8(rv & 8'h3F, 8'h00);
    smp(0, -1000, 0);
    u_ffod_host.rd(FFOD_ADDR_OR_SRC, rv);
    chk8(rv & 8'h3F, 8'h04);
    // same position again drops the level flag before latched mode
    smp(0, -1000, 0);
    chk1(int_o, 1'b0);
    $display("orientation level done");
    u_ffod_host.wr(FFOD_ADDR_OR_CFG, 8'h00);
    u_ffod_host.wr(FFOD_ADDR_INT_CFG, 8'h03);
    smp(1000, 0, 0);
    smp(0, 1000, 0);
    chk1(int_o, 1'b1);
    rdc(FFOD_ADDR_OR_SRC, 8'h48);
    gap2();
    chk1(int_o, 1'b0);
    // the pending change refused the up-Y move, so it is new now
    smp(0, 1000, 0);
    chk1(int_o, 1'b1);
    $display("orientation latched done");
    end_of_test();
  end
endmodule
